//--- core/plam_pkg.sv
package plam_pkg;
  // power and limits in signed hundredths of a dBm
  localparam int PWR_W = 16;
  localparam int NUM_CH = 2;
  localparam logic signed [PWR_W-1:0] LIMIT_MIN = 16'sh8ad0;
  localparam logic signed [PWR_W-1:0] LIMIT_MAX = 16'sh7530;
  localparam logic signed [PWR_W-1:0] LOWER_RST = 16'sh0000;
  localparam logic signed [PWR_W-1:0] UPPER_RST = 16'sh0000;
  localparam int FLAG_SUM = 4;
  localparam int FLAG_LO_ACT = 3;
  localparam int FLAG_HI_ACT = 2;
  localparam int FLAG_LO_LAT = 1;
  localparam int FLAG_HI_LAT = 0;

  typedef enum logic [2:0] {
    PLAM_CMD_NOP,
    PLAM_CMD_WR_LOWER,
    PLAM_CMD_WR_UPPER,
    PLAM_CMD_WR_LO_EN,
    PLAM_CMD_WR_HI_EN,
    PLAM_CMD_CLEAR,
    PLAM_CMD_READ
  } plam_cmd_type;

  typedef struct packed {
    logic                    valid;
    plam_cmd_type            op;
    logic                    chan;
    logic signed [PWR_W-1:0] value;
  } plam_req_type;

  typedef struct packed {
    logic                    valid;
    logic                    error;
    logic                    chan;
    logic signed [PWR_W-1:0] lower_threshold_value;
    logic signed [PWR_W-1:0] upper_threshold_value;
    logic                    lower_check_enable;
    logic                    upper_check_enable;
    logic [4:0]              alarm_status_query;
  } plam_rsp_type;

  typedef struct packed {
    logic                    valid;
    logic signed [PWR_W-1:0] power;
  } plam_meas_type;
endpackage

//--- core/plam_compare.sv
`timescale 1ns/100ps
`default_nettype none
module plam_compare
  import plam_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_in,
  input  wire plam_pkg::plam_meas_type meas_in,
  input  wire logic signed [PWR_W-1:0] lower_in,
  input  wire logic signed [PWR_W-1:0] upper_in,
  input  wire logic                    lo_en_in,
  input  wire logic                    hi_en_in,
  input  wire logic                    clear_in,
  output logic [3:0]                   flags_out
);
  typedef struct packed {
    logic lo_act;
    logic hi_act;
    logic lo_lat;
    logic hi_lat;
  } plam_cmp_state_type;

  plam_cmp_state_type s_reg;
  plam_cmp_state_type s_next;
  logic               lo_viol;
  logic               hi_viol;

  always_comb begin
    s_next = s_reg;
    lo_viol = lo_en_in && (meas_in.power < lower_in);
    hi_viol = hi_en_in && (meas_in.power > upper_in);
    if (!lo_en_in) begin
      s_next.lo_act = 1'b0;
    end
    if (!hi_en_in) begin
      s_next.hi_act = 1'b0;
    end
    if (clear_in) begin
      s_next.lo_lat = 1'b0;
      s_next.hi_lat = 1'b0;
    end
    if (meas_in.valid) begin
      s_next.lo_act = lo_viol;
      s_next.hi_act = hi_viol;
      if (lo_viol) begin
        s_next.lo_lat = 1'b1;
      end
      if (hi_viol) begin
        s_next.hi_lat = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags_out = {s_reg.lo_act, s_reg.hi_act, s_reg.lo_lat, s_reg.hi_lat};
endmodule
`default_nettype wire

//--- core/plam_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module plam_monitor
  import plam_pkg::*;
#(
  parameter bit DUAL_CHANNEL = 1'b1
)(
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_in,
  input  wire plam_pkg::plam_req_type  req_in,
  input  wire plam_pkg::plam_meas_type meas_ch0_in,
  input  wire plam_pkg::plam_meas_type meas_ch1_in,
  output var  plam_pkg::plam_rsp_type  rsp_out,
  output var  logic [1:0]              under_range_out,
  output var  logic [1:0]              over_range_out
);
  import plam_pkg::*;

  typedef struct packed {
    logic signed [NUM_CH-1:0][PWR_W-1:0] lower;
    logic signed [NUM_CH-1:0][PWR_W-1:0] upper;
    logic [NUM_CH-1:0]                   lo_en;
    logic [NUM_CH-1:0]                   hi_en;
    plam_rsp_type                        rsp;
  } plam_state_type;

  plam_state_type          s_reg;
  plam_state_type          s_next;
  logic [NUM_CH-1:0]       clear;
  logic [NUM_CH-1:0][3:0]  flags;
  plam_meas_type [NUM_CH-1:0] meas;
  logic                    refused;
  logic                    ch;

  assign meas[0] = meas_ch0_in;
  assign meas[1] = meas_ch1_in;

  // per-channel comparators, inputs from acquisition results, thresholds, enables and clear commands
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      plam_compare u_cmp (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .meas_in     (meas[g]),
        .lower_in    (s_reg.lower[g]),
        .upper_in    (s_reg.upper[g]),
        .lo_en_in    (s_reg.lo_en[g]),
        .hi_en_in    (s_reg.hi_en[g]),
        .clear_in    (clear[g]),
        .flags_out   (flags[g])
      );
      assign under_range_out[g] = flags[g][FLAG_LO_ACT];
      assign over_range_out[g]  = flags[g][FLAG_HI_ACT];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // command decode
  always_comb begin
    s_next = s_reg;
    ch = req_in.chan;
    refused = req_in.valid && ch && !DUAL_CHANNEL;
    clear = '0;
    s_next.rsp = '0;
    if (req_in.valid && req_in.op != PLAM_CMD_NOP) begin
      s_next.rsp.valid = 1'b1;
      s_next.rsp.chan = ch;
      s_next.rsp.error = refused;
      if (!refused) begin
        unique case (req_in.op)
          PLAM_CMD_WR_LOWER: s_next.lower[ch] = req_in.value;
          PLAM_CMD_WR_UPPER: s_next.upper[ch] = req_in.value;
          PLAM_CMD_WR_LO_EN: s_next.lo_en[ch] = req_in.value[0];
          PLAM_CMD_WR_HI_EN: s_next.hi_en[ch] = req_in.value[0];
          PLAM_CMD_CLEAR:    clear[ch] = 1'b1;
          default: begin
          end
        endcase
        s_next.rsp.lower_threshold_value = s_reg.lower[ch];
        s_next.rsp.upper_threshold_value = s_reg.upper[ch];
        s_next.rsp.lower_check_enable = s_reg.lo_en[ch];
        s_next.rsp.upper_check_enable = s_reg.hi_en[ch];
        s_next.rsp.alarm_status_query[FLAG_SUM] = |flags[ch];
        s_next.rsp.alarm_status_query[FLAG_LO_ACT] =
          flags[ch][FLAG_LO_ACT];
        s_next.rsp.alarm_status_query[FLAG_HI_ACT] =
          flags[ch][FLAG_HI_ACT];
        s_next.rsp.alarm_status_query[FLAG_LO_LAT] =
          flags[ch][FLAG_LO_LAT];
        s_next.rsp.alarm_status_query[FLAG_HI_LAT] =
          flags[ch][FLAG_HI_LAT];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_reg.lower <= {NUM_CH{LOWER_RST}};
      s_reg.upper <= {NUM_CH{UPPER_RST}};
      s_reg.lo_en <= '0;
      s_reg.hi_en <= '0;
      s_reg.rsp   <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rsp_out = s_reg.rsp;
endmodule
`default_nettype wire

//--- verification/plam_monitor_sva.sv
`timescale 1ns/100ps
`default_nettype none
module plam_monitor_sva
  import plam_pkg::*;
#(parameter bit DUAL_CHANNEL = 1'b1)(
  input wire logic                   core_clk_in,
  input wire logic                   rst_in,
  input wire plam_pkg::plam_req_type  req_in,
  input wire plam_pkg::plam_meas_type meas_ch0_in,
  input wire plam_pkg::plam_meas_type meas_ch1_in,
  input wire plam_pkg::plam_rsp_type  rsp_out,
  input wire logic [1:0]             under_range_out,
  input wire logic [1:0]             over_range_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence take_s;
    req_in.valid && req_in.op != PLAM_CMD_NOP;
  endsequence
  a_rsp_follows: assert property (take_s |=> rsp_out.valid)
    else $error("no response");
  a_rsp_only: assert property (rsp_out.valid |->
    $past(req_in.valid) && $past(req_in.op) != PLAM_CMD_NOP)
    else $error("spurious response");
  a_rsp_chan: assert property (take_s |=>
    rsp_out.chan == $past(req_in.chan)) else $error("wrong channel");
  a_chan_refused: assert property ((req_in.valid && req_in.chan &&
    req_in.op != PLAM_CMD_NOP && !DUAL_CHANNEL) |=>
    rsp_out.error && rsp_out.alarm_status_query == 5'h0)
    else $error("second channel not refused");
  a_summary_or: assert property (rsp_out.valid |->
    rsp_out.alarm_status_query[4] == |rsp_out.alarm_status_query[3:0])
    else $error("summary wrong");
  a_under_cause: assert property ($rose(under_range_out[0]) |->
    $past(meas_ch0_in.valid, 1) || $past(meas_ch0_in.valid, 2))
    else $error("under rise without result");
  a_over_cause: assert property ($rose(over_range_out[1]) |->
    $past(meas_ch1_in.valid, 1) || $past(meas_ch1_in.valid, 2))
    else $error("over rise without result");
  a_under_drop: assert property ($fell(under_range_out[1]) |->
    $past(meas_ch1_in.valid || req_in.valid, 1) ||
    $past(meas_ch1_in.valid || req_in.valid, 2))
    else $error("under drop without cause");
endmodule
bind plam_monitor plam_monitor_sva #(.DUAL_CHANNEL(DUAL_CHANNEL)) u_sva (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req_in),
  .meas_ch0_in(meas_ch0_in), .meas_ch1_in(meas_ch1_in), .rsp_out(rsp_out),
  .under_range_out(under_range_out), .over_range_out(over_range_out));
`default_nettype wire

//--- verification/plam_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module plam_host_model
  import plam_pkg::*;
(
  input  wire logic             core_clk_in,
  output plam_pkg::plam_req_type req_out
);
  initial req_out = '0;
  task automatic issue(plam_cmd_type op, logic ch, logic signed [15:0] v);
    logic signed [15:0] c;
    c = v < LIMIT_MIN ? LIMIT_MIN : v;
    c = c > LIMIT_MAX ? LIMIT_MAX : c;
    @(posedge core_clk_in);
    req_out <= '{1'b1, op, ch, c};
    @(posedge core_clk_in);
    req_out.valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/test_plam_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module test_plam_monitor;
  import plam_pkg::*;
  logic core_clk_in = 0, rst_in = 1;
  plam_req_type req;
  plam_meas_type m0 = '0, m1 = '0;
  plam_rsp_type rsp, rsp1;
  logic [1:0] ur, ov;
  int fail_count = 0, samples_checked = 0, ch, k;
  logic signed [15:0] lo[2] = '{0, 0}, hi[2] = '{0, 0}, p;
  logic le[2] = '{0, 0}, he[2] = '{0, 0}, la[2] = '{0, 0}, ha[2] = '{0, 0};
  logic ll[2] = '{0, 0}, hl[2] = '{0, 0};
  always #4 core_clk_in = ~core_clk_in;
  plam_host_model host (.core_clk_in(core_clk_in), .req_out(req));
  plam_monitor dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
    .meas_ch0_in(m0), .meas_ch1_in(m1), .rsp_out(rsp),
    .under_range_out(ur), .over_range_out(ov));
  plam_monitor #(.DUAL_CHANNEL(1'b0)) dut_single (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .req_in(req), .meas_ch0_in(m0), .meas_ch1_in(m1),
    .rsp_out(rsp1), .under_range_out(), .over_range_out());
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (e !== s) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [4:0] exp_status(int c);
    return {la[c] | ha[c] | ll[c] | hl[c], la[c], ha[c], ll[c], hl[c]};
  endfunction
  task automatic meas(int c, logic signed [15:0] v);
    @(posedge core_clk_in);
    if (c) m1 <= '{1'b1, v}; else m0 <= '{1'b1, v};
    @(posedge core_clk_in);
    m0.valid <= 1'b0;
    m1.valid <= 1'b0;
    if (le[c]) la[c] = v < lo[c];
    if (he[c]) ha[c] = v > hi[c];
    ll[c] |= la[c];
    hl[c] |= ha[c];
  endtask
  task automatic cmd(plam_cmd_type op, int c, logic signed [15:0] v);
    host.issue(op, c[0], v);
    #1;
    chk("valid", 1, rsp.valid);
    chk("refused", c[0], rsp1.error);
    if (op == PLAM_CMD_WR_LOWER) lo[c] = v;
    if (op == PLAM_CMD_WR_UPPER) hi[c] = v;
    if (op == PLAM_CMD_WR_LO_EN) le[c] = v[0];
    if (op == PLAM_CMD_WR_HI_EN) he[c] = v[0];
    la[c] &= le[c];
    ha[c] &= he[c];
    if (op == PLAM_CMD_CLEAR) ll[c] = 0;
    if (op == PLAM_CMD_CLEAR) hl[c] = 0;
  endtask
  task automatic rd(int c);
    cmd(PLAM_CMD_READ, c, 16'h0000);
    chk("status", exp_status(c), rsp.alarm_status_query);
    chk("lower", lo[c], rsp.lower_threshold_value);
    chk("upper", hi[c], rsp.upper_threshold_value);
    chk("enables", {le[c], he[c]},
      {rsp.lower_check_enable, rsp.upper_check_enable});
    chk("under", la[c], ur[c]);
    chk("over", ha[c], ov[c]);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_in);
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'ha9b5_9213));
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(0);
    rd(1);
    host.issue(PLAM_CMD_NOP, 1'b0, 16'h0000);
    #1;
    chk("nop", 0, rsp.valid);
    for (k = 0; k < 400; k++) begin
      ch = $urandom % 2;
      p = 16'(int'($urandom_range(0, 4000)) - 2000);
      if ($urandom % 3 == 0) p = ($urandom % 2) ? lo[ch] : hi[ch];
      if ($urandom % 2) meas(ch, p);
      else cmd(plam_cmd_type'(1 + $urandom % 5), ch, p);
      rd(ch);
    end
    final_report();
  end
endmodule
`default_nettype wire
